// *** usb_pkg.sv ***
/*
 * Package for the serial status and baud generator block: register offsets,
 * field positions, reset values and parity mode codes.
 * Assumes a 32-bit APB with byte addresses; each register sits in one aligned word.
 */
package usb_pkg;
    // Printed offsets are not all multiples of four, so each is an index; byte address is index times four.
    localparam logic [15:0] USB_IDX_RX_ERROR_STATUS   = 16'hff93;
    localparam logic [15:0] USB_IDX_TX_STATUS         = 16'hff95;
    localparam logic [15:0] USB_IDX_BASE_CLOCK_SELECT = 16'hff96;
    localparam logic [15:0] USB_IDX_BASE_DIVISOR      = 16'hff97;
    localparam logic [15:0] USB_IDX_SERIAL_MODE_CTRL  = 16'hff90;
    localparam logic [15:0] USB_IDX_TRANSMIT_BUFFER   = 16'hff91;
    localparam logic [15:0] USB_IDX_RECEIVE_BUFFER    = 16'hff92;
    localparam logic [17:0] USB_ADDR_RX_ERROR_STATUS   = {USB_IDX_RX_ERROR_STATUS, 2'b00};
    localparam logic [17:0] USB_ADDR_TX_STATUS         = {USB_IDX_TX_STATUS, 2'b00};
    localparam logic [17:0] USB_ADDR_BASE_CLOCK_SELECT = {USB_IDX_BASE_CLOCK_SELECT, 2'b00};
    localparam logic [17:0] USB_ADDR_BAUD_DIVISOR      = {USB_IDX_BASE_DIVISOR, 2'b00};
    localparam logic [17:0] USB_ADDR_SERIAL_MODE_CTRL  = {USB_IDX_SERIAL_MODE_CTRL, 2'b00};
    localparam logic [17:0] USB_ADDR_TRANSMIT_BUFFER   = {USB_IDX_TRANSMIT_BUFFER, 2'b00};
    localparam logic [17:0] USB_ADDR_RECEIVE_BUFFER    = {USB_IDX_RECEIVE_BUFFER, 2'b00};
    // Error status bits.
    localparam int USB_BIT_PARITY_ERR  = 2;
    localparam int USB_BIT_FRAMING_ERR = 1;
    localparam int USB_BIT_OVERRUN     = 0;
    // Transmit status bits.
    localparam int USB_BIT_TX_BUFFER_FULL = 1;
    localparam int USB_BIT_TX_SHIFT_BUSY  = 0;
    // Mode control bits.
    localparam int USB_BIT_POWER   = 7;
    localparam int USB_BIT_TX_EN   = 6;
    localparam int USB_BIT_RX_EN   = 5;
    localparam int USB_BIT_PAR_HI  = 4;
    localparam int USB_BIT_PAR_LO  = 3;
    localparam int USB_BIT_CHAR8   = 2;
    localparam int USB_BIT_STOP2   = 1;
    // Reset values, prescale code limit and divisor minimum.
    localparam logic [7:0] USB_RST_MODE_CTRL = 8'h01;
    localparam logic [7:0] USB_RST_CLK_SEL   = 8'h00;
    localparam logic [7:0] USB_RST_DIVISOR   = 8'hff;
    localparam logic [3:0] USB_PRESCALE_MAX  = 4'hb;
    localparam logic [7:0] USB_DIVISOR_MIN   = 8'h08;
    // Parity mode codes.
    typedef enum logic [1:0] {
        USB_PAR_NONE = 2'h0,
        USB_PAR_ZERO = 2'h1,
        USB_PAR_ODD  = 2'h2,
        USB_PAR_EVEN = 2'h3
    } usb_parity_type;
endpackage

// *** usb_uart_status.sv ***
/*
 * Serial transceiver status and baud generation: error flags, transmit buffer
 * and shifter status, base clock prescaler, 8-bit divisor, and a simple
 * transmit and receive framer that produces the events behind the flags.
 * Assumes an APB master on core_clk and an asynchronous receive line.
 */
// Functional notes
// - Parity mismatch on completed reception sets parity error bit 2.
// - Missing high stop bit on completed reception sets framing error bit 1.
// - Character completing while buffer unread sets overrun bit 0.
// - Error flags clear on status read and while power and receive are off.
// - On overrun the new character is dropped, buffer keeps old data.
// - Only the first stop bit is checked, whatever stop count is set.
// - Parity error evaluation follows the parity mode field.
// - Buffer full sets on write, clears on transfer or power/transmit off.
// - Shift busy sets on transfer, clears at frame end with nothing pending.
// - Transmit status reads zero while power or transmit enable is off.
// - Base clock is peripheral clock over two to the code, codes 0 to 11.
// - Eight-bit counter divides base clock by k from 8 to 255.
// - Bit rate is the counter output frequency halved.
// - Rewriting the same clock select or divisor value does not disturb traffic.
// - Reset sets divisor to ff and clock select to 00.
// - Error status reads zero while power or receive enable is off.
// - Status registers are read-only whole bytes; writes leave flags alone.
// - Zero parity mode never judges parity, so no parity error.
// - Power off stops the clock and resets status and receive buffer; flags reset only if receive enable is also off.
`timescale 1ns/100ps
module usb_uart_status
    import usb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_line,
    output logic             tx_line
);
    typedef enum logic [1:0] {USB_IDLE, USB_DATA, USB_PAR, USB_STOP} usb_fsm_type;

    logic [7:0] mode_reg;
    logic [7:0] clk_sel_reg;
    logic [7:0] divisor_reg;
    logic [7:0] receive_buffer_reg;
    logic       rx_full_reg;
    logic [2:0] err_reg;
    logic [7:0] transmit_buffer_reg;
    logic       tx_buffer_full_reg;
    logic       tx_shift_busy_reg;
    logic [10:0] pre_cnt_reg;
    logic [7:0] div_cnt_reg;
    logic       half_reg;
    logic [2:0] rx_sync_reg;
    logic       rx_stable_reg;

    logic       unit_power_on;
    logic       transmit_enable;
    logic       receive_enable;
    usb_parity_type parity_mode;
    logic       base_tick;
    logic       div_tick;
    logic       sample_tick;
    logic       bit_tick;
    logic       wr_en;
    logic       rd_en;
    logic       tx_reg_write;
    logic       err_read;
    logic       rx_done;
    logic       rx_par_bad;
    logic       rx_frm_bad;
    logic [7:0] rx_char;
    logic       tx_frame_end;
    logic       tx_load;
    logic [17:0] word_addr;

    assign unit_power_on   = mode_reg[USB_BIT_POWER];
    assign transmit_enable = unit_power_on && mode_reg[USB_BIT_TX_EN];
    assign receive_enable  = unit_power_on && mode_reg[USB_BIT_RX_EN];
    assign parity_mode     = usb_parity_type'(mode_reg[USB_BIT_PAR_HI:USB_BIT_PAR_LO]);

    // Decides whether a bus address hits a given register word.
    function automatic logic hit(input logic [17:0] a, input logic [17:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // Zero-wait APB slave; unmapped addresses answer with pslverr.
    assign word_addr    = {paddr[17:2], 2'b00};
    assign pready       = 1'b1;
    assign wr_en        = psel && penable && pwrite;
    assign rd_en        = psel && penable && !pwrite;
    assign tx_reg_write = wr_en && pstrb[0] && hit(word_addr, USB_ADDR_TRANSMIT_BUFFER);
    assign err_read     = rd_en && hit(word_addr, USB_ADDR_RX_ERROR_STATUS);

    always_comb begin
        if (paddr[31:18] != 14'h0000) begin
            pslverr = psel && penable;
        end else if (hit(word_addr, USB_ADDR_RX_ERROR_STATUS) || hit(word_addr, USB_ADDR_TX_STATUS) ||
                     hit(word_addr, USB_ADDR_BASE_CLOCK_SELECT) || hit(word_addr, USB_ADDR_BAUD_DIVISOR) ||
                     hit(word_addr, USB_ADDR_SERIAL_MODE_CTRL) || hit(word_addr, USB_ADDR_TRANSMIT_BUFFER) ||
                     hit(word_addr, USB_ADDR_RECEIVE_BUFFER)) begin
            pslverr = 1'b0;
        end else begin
            pslverr = psel && penable;
        end
    end

    // Read data is registered in the setup phase so the data output comes from flops.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (hit(word_addr, USB_ADDR_RX_ERROR_STATUS)) begin
                prdata <= {29'h0, receive_enable ? err_reg : 3'h0};
            end else if (hit(word_addr, USB_ADDR_TX_STATUS)) begin
                prdata <= {30'h0, tx_buffer_full_reg, tx_shift_busy_reg};
            end else if (hit(word_addr, USB_ADDR_BASE_CLOCK_SELECT)) begin
                prdata <= {24'h0, clk_sel_reg};
            end else if (hit(word_addr, USB_ADDR_BAUD_DIVISOR)) begin
                prdata <= {24'h0, divisor_reg};
            end else if (hit(word_addr, USB_ADDR_SERIAL_MODE_CTRL)) begin
                prdata <= {24'h0, mode_reg};
            end else if (hit(word_addr, USB_ADDR_RECEIVE_BUFFER)) begin
                prdata <= {24'h0, receive_buffer_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Control registers; status words ignore writes.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_reg    <= USB_RST_MODE_CTRL;
            clk_sel_reg <= USB_RST_CLK_SEL;
            divisor_reg <= USB_RST_DIVISOR;
        end else if (wr_en && pstrb[0]) begin
            if (hit(word_addr, USB_ADDR_SERIAL_MODE_CTRL)) begin
                mode_reg <= pwdata[7:0];
            end else if (hit(word_addr, USB_ADDR_BASE_CLOCK_SELECT)) begin
                clk_sel_reg <= {4'h0, pwdata[3:0]};
            end else if (hit(word_addr, USB_ADDR_BAUD_DIVISOR)) begin
                divisor_reg <= pwdata[7:0];
            end
        end
    end

    // Prescaler: a free counter whose bit code-1 rising to one marks a base clock tick.
    // A same-value rewrite leaves the counters untouched, so traffic is undisturbed.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !unit_power_on) begin
            pre_cnt_reg <= 11'h000;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 11'h001;
        end
    end

    always_comb begin
        if (clk_sel_reg[3:0] == 4'h0) begin
            base_tick = unit_power_on;
        end else if (clk_sel_reg[3:0] > USB_PRESCALE_MAX) begin
            base_tick = 1'b0;
        end else begin
            base_tick = unit_power_on && (pre_cnt_reg & ((11'h001 << (clk_sel_reg[3:0] - 4'h1)) - 11'h001)) == 11'h000
                        && pre_cnt_reg[clk_sel_reg[3:0] - 4'h1] == 1'b1;
        end
    end

    // Divisor counter; each output tick is half a bit, so two make one bit.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !unit_power_on) begin
            div_cnt_reg <= 8'h00;
            half_reg    <= 1'b0;
        end else if (base_tick) begin
            if (div_cnt_reg >= divisor_reg - 8'h01 || divisor_reg < USB_DIVISOR_MIN) begin
                div_cnt_reg <= 8'h00;
                half_reg    <= !half_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
            end
        end
    end
    assign div_tick    = base_tick && (div_cnt_reg >= divisor_reg - 8'h01) && divisor_reg >= USB_DIVISOR_MIN;
    assign bit_tick    = div_tick && half_reg;
    assign sample_tick = div_tick && !half_reg;

    // Three-stage receive synchroniser; a change counts once stages two and three agree.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_sync_reg   <= 3'b111;
            rx_stable_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], unit_power_on ? rx_line : 1'b1};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_stable_reg <= rx_sync_reg[2];
            end
        end
    end

    // Receive framer: start, data, optional parity, one stop, sampled once per bit.
    // The divider runs free and is not realigned on the start edge, so the sample point
    // may sit anywhere within a bit; one divider serves both directions, at the cost of
    // little margin against a partner whose clock differs.
    usb_fsm_type rx_state_reg;
    logic [3:0]  rx_cnt_reg;
    logic [7:0]  rx_shift_reg;
    logic        rx_par_reg;
    logic [3:0]  rx_bits;
    assign rx_bits = mode_reg[USB_BIT_CHAR8] ? 4'h8 : 4'h7;

    always_ff @(posedge core_clk) begin
        if (!rst_n || !receive_enable) begin
            rx_state_reg  <= USB_IDLE;
            rx_cnt_reg    <= 4'h0;
            rx_shift_reg  <= 8'h00;
            rx_par_reg    <= 1'b0;
        end else if (sample_tick) begin
            case (rx_state_reg)
                USB_IDLE: begin
                    // A second confirming sample would already fall in data bit 0, so one low sample starts a frame.
                    if (!rx_stable_reg) begin
                        rx_state_reg <= USB_DATA;
                        rx_cnt_reg   <= 4'h0;
                        rx_par_reg   <= 1'b0;
                    end
                end
                USB_DATA: begin
                    rx_shift_reg <= {rx_stable_reg, rx_shift_reg[7:1]};
                    rx_par_reg   <= rx_par_reg ^ rx_stable_reg;
                    rx_cnt_reg   <= rx_cnt_reg + 4'h1;
                    if (rx_cnt_reg == rx_bits - 4'h1) begin
                        rx_state_reg <= (parity_mode == USB_PAR_NONE) ? USB_STOP : USB_PAR;
                    end
                end
                USB_PAR: begin
                    rx_par_reg   <= rx_par_reg ^ rx_stable_reg;
                    rx_state_reg <= USB_STOP;
                end
                USB_STOP: begin
                    rx_state_reg <= USB_IDLE;
                end
                default: begin
                    rx_state_reg <= USB_IDLE;
                end
            endcase
        end
    end

    assign rx_done    = sample_tick && rx_state_reg == USB_STOP;
    assign rx_frm_bad = !rx_stable_reg;
    // Odd mode wants an odd total of ones, even mode an even total.
    assign rx_par_bad = (parity_mode == USB_PAR_ODD)  ? !rx_par_reg :
                        (parity_mode == USB_PAR_EVEN) ? rx_par_reg : 1'b0;
    assign rx_char    = mode_reg[USB_BIT_CHAR8] ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};

    // Receive buffer holds the oldest unread character; overrun drops the new one.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !unit_power_on) begin
            receive_buffer_reg <= 8'h00;
            rx_full_reg        <= 1'b0;
        end else if (rx_done && !rx_full_reg) begin
            receive_buffer_reg <= rx_char;
            rx_full_reg        <= 1'b1;
        end else if (rd_en && hit(word_addr, USB_ADDR_RECEIVE_BUFFER)) begin
            rx_full_reg <= 1'b0;
        end
    end

    // Error flags; a new event beats the read that clears them.
    always_ff @(posedge core_clk) begin
        if (!rst_n || (!unit_power_on && !mode_reg[USB_BIT_RX_EN])) begin
            err_reg <= 3'h0;
        end else if (rx_done) begin
            err_reg[USB_BIT_PARITY_ERR]  <= rx_par_bad || (err_reg[USB_BIT_PARITY_ERR] && !err_read);
            err_reg[USB_BIT_FRAMING_ERR] <= rx_frm_bad || (err_reg[USB_BIT_FRAMING_ERR] && !err_read);
            err_reg[USB_BIT_OVERRUN]     <= rx_full_reg || (err_reg[USB_BIT_OVERRUN] && !err_read);
        end else if (err_read) begin
            err_reg <= 3'h0;
        end
    end

    // Transmitter: buffer to shifter, then start, data, parity and stop bits.
    logic [10:0] tx_shift_reg;
    logic [3:0]  tx_left_reg;
    logic        tx_par;
    logic [3:0]  tx_len;
    logic [10:0] tx_frame;

    assign tx_par = (parity_mode == USB_PAR_ODD)  ? !(^transmit_buffer_reg[6:0] ^ (mode_reg[USB_BIT_CHAR8] &
                                                     transmit_buffer_reg[7])) :
                    (parity_mode == USB_PAR_EVEN) ? (^transmit_buffer_reg[6:0] ^ (mode_reg[USB_BIT_CHAR8] &
                                                     transmit_buffer_reg[7])) : 1'b0;
    always_comb begin
        tx_frame = 11'h7ff;
        tx_len   = 4'h1 + (mode_reg[USB_BIT_CHAR8] ? 4'h8 : 4'h7) + (parity_mode != USB_PAR_NONE ? 4'h1 : 4'h0)
                   + (mode_reg[USB_BIT_STOP2] ? 4'h2 : 4'h1);
        if (mode_reg[USB_BIT_CHAR8]) begin
            tx_frame[8:0] = {transmit_buffer_reg, 1'b0};
        end else begin
            tx_frame[7:0] = {transmit_buffer_reg[6:0], 1'b0};
        end
        if (parity_mode != USB_PAR_NONE) begin
            tx_frame[rx_bits + 4'h1] = tx_par;
        end
    end

    assign tx_frame_end = bit_tick && tx_shift_busy_reg && tx_left_reg == 4'h1;
    assign tx_load      = tx_buffer_full_reg && (!tx_shift_busy_reg || tx_frame_end) && bit_tick;

    always_ff @(posedge core_clk) begin
        if (!rst_n || !transmit_enable) begin
            tx_shift_reg      <= 11'h7ff;
            tx_left_reg       <= 4'h0;
            tx_shift_busy_reg <= 1'b0;
        end else if (tx_load) begin
            tx_shift_reg      <= tx_frame;
            tx_left_reg       <= tx_len;
            tx_shift_busy_reg <= 1'b1;
        end else if (bit_tick && tx_shift_busy_reg) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_left_reg  <= tx_left_reg - 4'h1;
            if (tx_frame_end) begin
                tx_shift_busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !transmit_enable) begin
            transmit_buffer_reg <= 8'h00;
            tx_buffer_full_reg  <= 1'b0;
        end else if (tx_reg_write) begin
            transmit_buffer_reg <= pwdata[7:0];
            tx_buffer_full_reg  <= 1'b1;
        end else if (tx_load) begin
            tx_buffer_full_reg <= 1'b0;
        end
    end

    // Line idles high whenever the shifter is not busy.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_line <= 1'b1;
        end else begin
            tx_line <= tx_shift_busy_reg ? tx_shift_reg[0] : 1'b1;
        end
    end

    chk_tx_off_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        !transmit_enable |=> !tx_buffer_full_reg && !tx_shift_busy_reg) else $error("tx status not cleared");
    chk_write_sets_full: assert property (@(posedge core_clk) disable iff (!rst_n)
        tx_reg_write && transmit_enable |=> tx_buffer_full_reg) else $error("buffer full not set");
    chk_overrun_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_done && rx_full_reg |=> $stable(receive_buffer_reg) && err_reg[0]) else $error("overrun mishandled");
    chk_read_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        err_read && !rx_done |=> err_reg == 3'h0) else $error("errors not cleared");
    chk_zero_parity: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_done && parity_mode == USB_PAR_ZERO |=> !$rose(err_reg[2])) else $error("zero parity judged");
    chk_framing_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        rx_done && !rx_stable_reg |=> err_reg[1]) else $error("framing not flagged");
    chk_load_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        tx_load && transmit_enable |=> tx_shift_busy_reg && !tx_buffer_full_reg) else $error("load failed");
    chk_power_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        !unit_power_on |=> !rx_full_reg && div_cnt_reg == 8'h00) else $error("power off reset failed");
    chk_div_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        divisor_reg >= USB_DIVISOR_MIN |-> div_cnt_reg < divisor_reg) else $error("divisor overran");
    cov_rx_done: cover property (@(posedge core_clk) rx_done);
    cov_overrun: cover property (@(posedge core_clk) rx_done && rx_full_reg);
    cov_back_to_back: cover property (@(posedge core_clk) tx_load && tx_frame_end);
endmodule

// *** usb_partner.sv ***
/* Remote serial partner: sends frames on rx_line, captures frames from tx_line.
   Assumes 8 data bits, LSB first, and a bit time of bit_len core_clk cycles, which starts at BIT. */
`timescale 1ns/100ps
module usb_partner #(parameter int BIT = 16) (
    input  wire logic core_clk,
    output logic      rx_line,
    input  wire logic tx_line
);
    logic [7:0] got;
    int         bit_len = BIT; // The bench changes it when it picks another prescale code.
    initial rx_line = 1'b1;
    // Parity and stop level are arguments so that faults can be commanded.
    task automatic send(input logic [7:0] d, input logic par_on, input logic par, input logic stp);
        logic [10:0] f;
        f = {stp, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || par_on) begin
                rx_line <= f[i];
                repeat (bit_len) @(posedge core_clk);
            end
        end
        rx_line <= 1'b1; // The line idles high, as if pulled up.
        repeat (2 * bit_len) @(posedge core_clk);
    endtask
    // Samples each data bit at its middle; parity is skipped, not judged.
    task automatic recv(input logic par_on);
        @(negedge tx_line);
        repeat (bit_len / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_len) @(posedge core_clk);
            got[i] = tx_line;
        end
        repeat ((par_on ? 2 : 1) * bit_len) @(posedge core_clk);
    endtask
endmodule

// *** uart_status_and_baud_gen_bench.sv ***
/* Self-checking bench for the serial status and baud block.
   Assumes divisor 8: code 0 gives bits of 16 core_clk cycles, code 1 bits of 32. */
`timescale 1ns/100ps
module uart_status_and_baud_gen_bench import usb_pkg::*; ;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, rx_line, tx_line, e;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [7:0]  g0, g1, d;
    int          err_total = 0, compares = 0, cyc = 0;
    usb_uart_status dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line));
    usb_partner #(.BIT(16)) u_partner (.core_clk(core_clk), .rx_line(rx_line), .tx_line(tx_line));
    // Clock at 40 MHz, and a ceiling far above the expected run length.
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic xfer(input logic wr, input logic [17:0] a, input logic [7:0] v);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {14'h0000, a};
        pwdata <= {24'h000000, v};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] x);
        xfer(1'b0, a, 8'h00);
        chk(r, {24'h000000, x});
    endtask
    // Main sequence; the error status is always read before the receive buffer.
    initial begin
        core_clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; pstrb = 4'hf;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(USB_ADDR_BAUD_DIVISOR, 8'hff);
        rd(USB_ADDR_BASE_CLOCK_SELECT, 8'h00);
        rd(USB_ADDR_RX_ERROR_STATUS, 8'h00);
        rd(USB_ADDR_TX_STATUS, 8'h00);
        xfer(1'b0, 18'h00100, 8'h00);
        chk({31'h0, e}, 32'h1);
        xfer(1'b1, USB_ADDR_BAUD_DIVISOR, 8'h08);
        rd(USB_ADDR_BAUD_DIVISOR, 8'h08);
        xfer(1'b1, USB_ADDR_TX_STATUS, 8'hff);
        rd(USB_ADDR_TX_STATUS, 8'h00);
        // Every parity mode; the parity bit sent is always one.
        for (int m = 0; m < 4; m++) begin
            d = 8'h96 + 8'(m);
            xfer(1'b1, USB_ADDR_SERIAL_MODE_CTRL, 8'h86 | 8'(m << 3));
            xfer(1'b1, USB_ADDR_SERIAL_MODE_CTRL, 8'he6 | 8'(m << 3));
            u_partner.send(d, m != 0, 1'b1, 1'b1);
            rd(USB_ADDR_RX_ERROR_STATUS, (m >= 2) ? 8'h04 : 8'h00);
            rd(USB_ADDR_RX_ERROR_STATUS, 8'h00);
            rd(USB_ADDR_RECEIVE_BUFFER, d);
        end
        u_partner.send(8'h5a, 1'b1, ^8'h5a, 1'b0);
        rd(USB_ADDR_RX_ERROR_STATUS, 8'h02);
        rd(USB_ADDR_RECEIVE_BUFFER, 8'h5a);
        u_partner.send(8'h11, 1'b1, ^8'h11, 1'b1);
        u_partner.send(8'h22, 1'b1, ^8'h22, 1'b1);
        rd(USB_ADDR_RX_ERROR_STATUS, 8'h01);
        rd(USB_ADDR_RECEIVE_BUFFER, 8'h11);
        fork
            begin
                u_partner.recv(1'b1);
                g0 = u_partner.got;
                u_partner.recv(1'b1);
                g1 = u_partner.got;
            end
            begin
                xfer(1'b1, USB_ADDR_TRANSMIT_BUFFER, 8'hc3);
                // The byte moves to the shifter at the next bit tick, up to one bit later.
                repeat (20) @(posedge core_clk);
                rd(USB_ADDR_TX_STATUS, 8'h01);
                xfer(1'b1, USB_ADDR_TRANSMIT_BUFFER, 8'h4e);
                rd(USB_ADDR_TX_STATUS, 8'h03);
                // Same-value rewrites in mid-frame must leave both bytes intact.
                xfer(1'b1, USB_ADDR_BAUD_DIVISOR, 8'h08);
                xfer(1'b1, USB_ADDR_BASE_CLOCK_SELECT, 8'h00);
            end
        join
        chk({24'h0, g0}, 32'hc3);
        chk({24'h0, g1}, 32'h4e);
        repeat (40) @(posedge core_clk);
        rd(USB_ADDR_TX_STATUS, 8'h00);
        u_partner.send(8'h77, 1'b1, ~^8'h77, 1'b0);
        xfer(1'b1, USB_ADDR_TRANSMIT_BUFFER, 8'h81);
        xfer(1'b1, USB_ADDR_SERIAL_MODE_CTRL, 8'h00);
        rd(USB_ADDR_RX_ERROR_STATUS, 8'h00);
        rd(USB_ADDR_TX_STATUS, 8'h00);
        // Power back on: the errors of the last frame and its buffered byte must be gone.
        xfer(1'b1, USB_ADDR_BASE_CLOCK_SELECT, 8'h01);
        rd(USB_ADDR_BASE_CLOCK_SELECT, 8'h01);
        xfer(1'b1, USB_ADDR_SERIAL_MODE_CTRL, 8'ha0);
        rd(USB_ADDR_RX_ERROR_STATUS, 8'h00);
        rd(USB_ADDR_RECEIVE_BUFFER, 8'h00);
        // Code 1 doubles the bit time; in 7-bit mode the eighth bit sent, a one, is the stop bit.
        u_partner.bit_len = 32;
        u_partner.send(8'hbc, 1'b0, 1'b0, 1'b1);
        rd(USB_ADDR_RX_ERROR_STATUS, 8'h00);
        rd(USB_ADDR_RECEIVE_BUFFER, 8'h3c);
        stop_test();
    end
endmodule
